// ==== cicp_pkg.sv ====
package cicp_pkg;
   localparam logic [11:0] CICP_ADDR_TVEC = 12'h305;
   localparam logic [11:0] CICP_ADDR_SYSCTL = 12'h804;
   localparam logic [11:0] CICP_ADDR_PMPCFG = 12'h3A0;
   localparam logic [11:0] CICP_ADDR_PMPADDR = 12'h3B0;
   localparam int CICP_ENTRIES = 4;
   localparam int CICP_SYS_HWSTK = 0;
   localparam int CICP_SYS_NEST = 1;
   localparam int CICP_SYS_GOFF = 5;
   localparam int CICP_TVEC_ENTRY = 0;
   localparam int CICP_TVEC_FORMAT = 1;
   localparam int CICP_CFG_R = 0;
   localparam int CICP_CFG_W = 1;
   localparam int CICP_CFG_X = 2;
   localparam int CICP_CFG_A = 3;
   localparam int CICP_CFG_L = 7;
   localparam logic [1:0] CICP_A_OFF = 2'h0;
   localparam logic [1:0] CICP_A_TOR = 2'h1;
   localparam logic [1:0] CICP_A_NA4 = 2'h2;
   localparam logic [1:0] CICP_A_NAPOT = 2'h3;
   localparam logic [7:0] CICP_CFG_MASK = 8'h9F;
   localparam logic [31:0] CICP_TVEC_RESET = 32'h0000_0000;
   localparam logic [7:0] CICP_CFG_RESET = 8'h00;
   localparam logic [31:0] CICP_PADDR_RESET = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } cicp_csr_req_t;

   typedef struct packed {
      logic done;
      logic denied;
      logic [31:0] rdata;
   } cicp_csr_rsp_t;

   typedef struct packed {
      logic valid;
      logic irq;
      logic [7:0] num;
   } cicp_trap_req_t;

   typedef struct packed {
      logic valid;
      logic user;
      logic read;
      logic write;
      logic exec;
      logic [31:0] addr;
   } cicp_mem_req_t;
endpackage

// ==== cicp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module cicp_top
(
   input wire logic clk, // core clock, 50 MHz
   input wire logic rst, // async reset, active high
   input wire logic priv_machine, // hart is in machine privilege
   input wire cicp_pkg::cicp_csr_req_t csr_req, // csr access from pipeline
   output var cicp_pkg::cicp_csr_rsp_t csr_rsp, // csr answer, next cycle
   input wire logic mret_done, // interrupt return completed
   input wire cicp_pkg::cicp_trap_req_t trap_req, // trap being taken
   output var logic trap_valid, // trap_pc is valid
   output var logic [31:0] trap_pc, // entry or vector slot address
   output var logic trap_vec_absolute, // slot holds an address to load
   output logic irq_global_enable, // interrupts may be taken
   output logic nesting_allowed, // preemption of running handler allowed
   output logic hw_stack_active, // push/pop context in hardware
   input wire cicp_pkg::cicp_mem_req_t mem_req, // memory access to check
   output var logic mem_done, // check result valid
   output var logic mem_fault // system exception request
);
   import cicp_pkg::*;

   logic [31:0] tvec;
   logic hwstk;
   logic nest;
   logic goff;
   logic [7:0] pcfg [CICP_ENTRIES];
   logic [31:0] paddr [CICP_ENTRIES];
   wire logic [CICP_ENTRIES-1:0] ent_hit;
   wire logic [CICP_ENTRIES-1:0] ent_ok;
   logic rsp_done;
   logic rsp_denied;
   logic [31:0] rsp_rdata;
   // the check works on word addresses, as the address registers hold them
   wire logic [31:0] word_addr = {2'b00, mem_req.addr[31:2]};

   // trailing ones of the address pick the power-of-two size
   function automatic logic napot_hit(input logic [31:0] wa, input logic [31:0] base);
      logic [31:0] care;
      care = ~(base ^ (base + 32'h0000_0001));
      napot_hit = ((wa ^ base) & care) == 32'h0000_0000;
   endfunction

   function automatic logic region_hit(input logic [1:0] mode, input logic [31:0] wa,
                                       input logic [31:0] lo, input logic [31:0] cur);
      case (mode)
         CICP_A_TOR: region_hit = (wa >= lo) && (wa < cur);
         CICP_A_NA4: region_hit = (wa == cur);
         CICP_A_NAPOT: region_hit = napot_hit(wa, cur);
         default: region_hit = 1'b0;
      endcase
   endfunction

   // field helpers shared by the write path and the access check
   function automatic logic [1:0] cfg_mode(input logic [7:0] cfg);
      cfg_mode = cfg[CICP_CFG_A +: 2];
   endfunction

   function automatic logic cfg_locked(input logic [7:0] cfg);
      cfg_locked = cfg[CICP_CFG_L];
   endfunction

   // an access of no kind at all is allowed; the core always sets one kind
   function automatic logic cfg_allows(input logic [7:0] cfg, input logic rd, input logic wr, input logic ex);
      cfg_allows = (~rd | cfg[CICP_CFG_R]) &
                   (~wr | cfg[CICP_CFG_W]) &
                   (~ex | cfg[CICP_CFG_X]);
   endfunction

   // csr decode
   wire logic acc_ok = csr_req.valid & priv_machine;
   wire logic wr_ok = acc_ok & csr_req.write;
   wire logic hit_tvec = csr_req.addr == CICP_ADDR_TVEC;
   wire logic hit_sys = csr_req.addr == CICP_ADDR_SYSCTL;
   wire logic hit_cfg = csr_req.addr == CICP_ADDR_PMPCFG;
   wire logic hit_addr = csr_req.addr[11:2] == CICP_ADDR_PMPADDR[11:2];
   wire logic [1:0] addr_idx = csr_req.addr[1:0];
   wire logic mapped = hit_tvec | hit_sys | hit_cfg | hit_addr;
   wire logic [31:0] cfg_word = {pcfg[3], pcfg[2], pcfg[1], pcfg[0]};
   wire logic [31:0] sys_word = {26'h000_0000, goff, 3'h0, nest, hwstk};

   logic [31:0] read_value;
   always_comb
   begin
      read_value = 32'h0000_0000;
      if (hit_tvec)
         read_value = tvec;
      else if (hit_sys)
         read_value = sys_word;
      else if (hit_cfg)
         read_value = cfg_word;
      else if (hit_addr)
         read_value = paddr[addr_idx];
   end

   // denied covers lower privilege and unmapped numbers; nothing is written then
   wire logic next_denied = ~priv_machine | ~mapped;

   // a refused read must not leak register contents, so its data is forced to zero
   wire logic [31:0] next_rdata = (acc_ok & mapped) ? read_value : 32'h0000_0000;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rsp_done <= 1'b0;
      else
         rsp_done <= csr_req.valid;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rsp_denied <= 1'b0;
      else
         rsp_denied <= csr_req.valid & next_denied;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rsp_rdata <= 32'h0000_0000;
      else
         rsp_rdata <= next_rdata;
   end

   assign csr_rsp = {rsp_done, rsp_denied, rsp_rdata};

   wire logic tvec_we = wr_ok & hit_tvec;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tvec <= CICP_TVEC_RESET;
      else if (tvec_we)
         tvec <= csr_req.wdata;
   end

   // only bits 0, 1 and 5 exist; the others read zero and ignore writes
   wire logic sys_we = wr_ok & hit_sys;
   wire logic next_hwstk = csr_req.wdata[CICP_SYS_HWSTK];
   wire logic next_nest = csr_req.wdata[CICP_SYS_NEST];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hwstk <= 1'b0;
      else if (sys_we)
         hwstk <= next_hwstk;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         nest <= 1'b0;
      else if (sys_we)
         nest <= next_nest;
   end

   // write one sets; software never clears, so a set racing a return wins
   wire logic goff_set = wr_ok & hit_sys & csr_req.wdata[CICP_SYS_GOFF];
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         goff <= 1'b0;
      else if (goff_set)
         goff <= 1'b1;
      else if (mret_done)
         goff <= 1'b0;
   end

   assign irq_global_enable = ~goff;
   assign nesting_allowed = nest & ~goff;
   assign hw_stack_active = hwstk & ~goff;

   // protection registers; a lock holds until reset
   genvar gi;
   generate
      for (gi = 0; gi < CICP_ENTRIES; gi++)
      begin : g_ent
         wire logic cfg_lock = cfg_locked(pcfg[gi]);
         // a locked top-of-range entry also freezes the address below it
         wire logic up_lock = (gi < CICP_ENTRIES - 1) &&
                              cfg_locked(pcfg[(gi + 1) % CICP_ENTRIES]) &&
                              (cfg_mode(pcfg[(gi + 1) % CICP_ENTRIES]) == CICP_A_TOR);
         wire logic cfg_we = wr_ok & hit_cfg & ~cfg_lock;
         wire logic addr_we = wr_ok & hit_addr & (addr_idx == 2'(gi)) & ~cfg_lock & ~up_lock;
         // entry 0 has no register below it, so its top-of-range starts at zero
         wire logic [31:0] lo_bound = (gi == 0) ? 32'h0000_0000 : paddr[(gi + CICP_ENTRIES - 1) % CICP_ENTRIES];

         assign ent_hit[gi] = region_hit(cfg_mode(pcfg[gi]), word_addr, lo_bound, paddr[gi]);
         assign ent_ok[gi] = cfg_allows(pcfg[gi], mem_req.read, mem_req.write, mem_req.exec);

         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               pcfg[gi] <= CICP_CFG_RESET;
            else if (cfg_we)
               pcfg[gi] <= csr_req.wdata[8 * gi +: 8] & CICP_CFG_MASK;
         end

         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               paddr[gi] <= CICP_PADDR_RESET;
            else if (addr_we)
               paddr[gi] <= csr_req.wdata;
         end
      end
   endgenerate

   // access check
   logic any_hit;
   logic perm_ok;
   logic hit_locked;
   always_comb
   begin
      any_hit = 1'b0;
      perm_ok = 1'b0;
      hit_locked = 1'b0;
      // walk downward so the lowest matching entry is written last
      for (int i = CICP_ENTRIES - 1; i >= 0; i--)
      begin
         if (ent_hit[i])
         begin
            any_hit = 1'b1;
            hit_locked = cfg_locked(pcfg[i]);
            perm_ok = ent_ok[i];
         end
      end
   end

   // user with no matching region is refused; machine is bound only by locked entries
   wire logic next_fault = mem_req.user ? (~any_hit | ~perm_ok) :
                                          (any_hit & hit_locked & ~perm_ok);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mem_done <= 1'b0;
      else
         mem_done <= mem_req.valid;
   end

   // the fault is a one-cycle pulse beside done; the core turns it into the exception
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mem_fault <= 1'b0;
      else
         mem_fault <= mem_req.valid & next_fault;
   end

   // trap entry
   wire logic [31:0] vec_base = {tvec[31:2], 2'b00};
   wire logic per_irq = tvec[CICP_TVEC_ENTRY] & trap_req.irq;
   wire logic [31:0] next_trap_pc = per_irq ? vec_base + {22'h00_0000, trap_req.num, 2'b00} :
                                              vec_base;

   // only a table slot can hold an address; a shared entry is code
   wire logic next_absolute = per_irq & tvec[CICP_TVEC_FORMAT];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         trap_valid <= 1'b0;
      else
         trap_valid <= trap_req.valid;
   end

   // address and format hold until the next trap so the core may fetch late
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         trap_pc <= 32'h0000_0000;
      else if (trap_req.valid)
         trap_pc <= next_trap_pc;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         trap_vec_absolute <= 1'b0;
      else if (trap_req.valid)
         trap_vec_absolute <= next_absolute;
   end
endmodule
`default_nettype wire

// ==== cicp_top_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module cicp_top_asserts
(
   input wire logic clk, // core clock
   input wire logic rst, // async reset
   input wire logic priv_machine, // machine privilege
   input wire cicp_pkg::cicp_csr_req_t csr_req, // csr access
   input wire cicp_pkg::cicp_csr_rsp_t csr_rsp, // csr answer
   input wire logic mret_done, // interrupt return
   input wire cicp_pkg::cicp_trap_req_t trap_req, // trap taken
   input wire logic trap_valid, // trap answer
   input wire logic [31:0] trap_pc, // entry address
   input wire logic irq_global_enable, // interrupts on
   input wire logic nesting_allowed, // preemption on
   input wire logic hw_stack_active, // stacking on
   input wire cicp_pkg::cicp_mem_req_t mem_req, // access to check
   input wire logic mem_done, // check done
   input wire logic mem_fault // system exception
);
   import cicp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic sys_wr = csr_req.valid && csr_req.write && priv_machine && csr_req.addr == CICP_ADDR_SYSCTL;
   property p_deny;
      csr_req.valid && !priv_machine && !mret_done |=> csr_rsp.denied && csr_rsp.rdata == 32'h0 && $stable(nesting_allowed);
   endproperty
   a_deny: assert property (p_deny) else $error("unprivileged access not refused");
   property p_set_off;
      sys_wr && csr_req.wdata[5] |=> !irq_global_enable && !nesting_allowed && !hw_stack_active;
   endproperty
   a_set_off: assert property (p_set_off) else $error("global off did not take effect");
   property p_off_gates;
      !irq_global_enable |-> !nesting_allowed && !hw_stack_active;
   endproperty
   a_off_gates: assert property (p_off_gates) else $error("stack or nesting live while off");
   property p_mret;
      mret_done && !(sys_wr && csr_req.wdata[5]) |=> irq_global_enable;
   endproperty
   a_mret: assert property (p_mret) else $error("return did not clear global off");
   property p_nest;
      sys_wr && !csr_req.wdata[5] && irq_global_enable |=> nesting_allowed == $past(csr_req.wdata[1]);
   endproperty
   a_nest: assert property (p_nest) else $error("nesting does not follow its bit");
   property p_stack;
      sys_wr && !csr_req.wdata[5] && irq_global_enable |=> hw_stack_active == $past(csr_req.wdata[0]);
   endproperty
   a_stack: assert property (p_stack) else $error("stacking does not follow its bit");
   property p_trap;
      trap_req.valid |=> trap_valid && trap_pc[1:0] == 2'h0;
   endproperty
   a_trap: assert property (p_trap) else $error("trap answer late or misaligned");
   property p_mem;
      mem_req.valid |=> mem_done;
   endproperty
   a_mem: assert property (p_mem) else $error("memory check not answered");
   property p_fault;
      mem_fault |-> mem_done && $past(mem_req.valid);
   endproperty
   a_fault: assert property (p_fault) else $error("fault without a checked access");
endmodule
bind cicp_top cicp_top_asserts chk_u (.clk(clk), .rst(rst), .priv_machine(priv_machine), .csr_req(csr_req),
   .csr_rsp(csr_rsp), .mret_done(mret_done), .trap_req(trap_req), .trap_valid(trap_valid), .trap_pc(trap_pc),
   .irq_global_enable(irq_global_enable), .nesting_allowed(nesting_allowed), .hw_stack_active(hw_stack_active),
   .mem_req(mem_req), .mem_done(mem_done), .mem_fault(mem_fault));
`default_nettype wire

// ==== cicp_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cicp_core_model
(
   input wire logic clk, // core clock
   input wire cicp_pkg::cicp_csr_rsp_t csr_rsp, // csr answer
   output var cicp_pkg::cicp_csr_req_t csr_req, // csr access
   output var cicp_pkg::cicp_trap_req_t trap_req, // trap request
   output var cicp_pkg::cicp_mem_req_t mem_req, // access to check
   output var logic mret_done // interrupt return pulse
);
   import cicp_pkg::*;
   initial
   begin
      csr_req = '0;
      trap_req = '0;
      mem_req = '0;
      mret_done = 1'b0;
   end
   // released fields carry inverted values, except the memory access kinds which drop to zero, so nothing relies on stale data
   task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d, output cicp_csr_rsp_t r);
      @(posedge clk);
      csr_req <= '{1'b1, w, a, d};
      @(posedge clk);
      csr_req <= '{1'b0, ~w, ~a, ~d};
      #1 r = csr_rsp;
   endtask
   task automatic trap(input logic irq, input logic [7:0] n);
      @(posedge clk);
      trap_req <= '{1'b1, irq, n};
      @(posedge clk);
      trap_req <= '{1'b0, ~irq, ~n};
      #1;
   endtask
   task automatic mem(input logic u, input logic [2:0] k, input logic [31:0] a);
      @(posedge clk);
      mem_req <= '{1'b1, u, k[2], k[1], k[0], a};
      @(posedge clk);
      mem_req <= '{1'b0, ~u, 1'b0, 1'b0, 1'b0, ~a};
      #1;
   endtask
   task automatic mret();
      @(posedge clk);
      mret_done <= 1'b1;
      @(posedge clk);
      mret_done <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

// ==== cicp_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module cicp_top_test;
   import cicp_pkg::*;
   logic clk;
   logic rst;
   logic priv_machine;
   cicp_csr_req_t csr_req;
   cicp_csr_rsp_t csr_rsp;
   cicp_trap_req_t trap_req;
   cicp_mem_req_t mem_req;
   logic mret_done, trap_valid, trap_vec_absolute, irq_global_enable, nesting_allowed, hw_stack_active;
   logic mem_done, mem_fault;
   logic [31:0] trap_pc;
   cicp_csr_rsp_t r;
   int failures = 0;
   int num_checks = 0;
   cicp_top dut_u (.clk(clk), .rst(rst), .priv_machine(priv_machine), .csr_req(csr_req), .csr_rsp(csr_rsp),
      .mret_done(mret_done), .trap_req(trap_req), .trap_valid(trap_valid), .trap_pc(trap_pc),
      .trap_vec_absolute(trap_vec_absolute), .irq_global_enable(irq_global_enable),
      .nesting_allowed(nesting_allowed), .hw_stack_active(hw_stack_active), .mem_req(mem_req),
      .mem_done(mem_done), .mem_fault(mem_fault));
   cicp_core_model core_u (.clk(clk), .csr_rsp(csr_rsp), .csr_req(csr_req), .trap_req(trap_req),
      .mem_req(mem_req), .mret_done(mret_done));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      core_u.csr(1'b1, a, d, r);
      `CHK({r.done, r.denied}, 2'h2)
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      core_u.csr(1'b0, a, 32'h0, r);
      `CHK(r.rdata, e)
   endtask
   task automatic chk_mem(input logic u, input logic [2:0] k, input logic [31:0] a, input logic f);
      core_u.mem(u, k, a);
      `CHK({mem_done, mem_fault}, {1'b1, f})
   endtask
   task automatic t_priv();
      rd(CICP_ADDR_TVEC, 32'h0);
      rd(CICP_ADDR_SYSCTL, 32'h0);
      @(posedge clk) priv_machine <= 1'b0;
      core_u.csr(1'b1, CICP_ADDR_SYSCTL, 32'h3, r);
      `CHK({r.denied, r.rdata, nesting_allowed}, {1'b1, 32'h0, 1'b0})
      @(posedge clk) priv_machine <= 1'b1;
      core_u.csr(1'b0, 12'h7C0, 32'h0, r);
      `CHK(r.denied, 1'b1)
   endtask
   task automatic t_sysctl();
      wr(CICP_ADDR_SYSCTL, 32'hFF);
      rd(CICP_ADDR_SYSCTL, 32'h23);
      `CHK({irq_global_enable, nesting_allowed, hw_stack_active}, 3'h0)
      core_u.mret();
      `CHK({irq_global_enable, nesting_allowed, hw_stack_active}, 3'h7)
      wr(CICP_ADDR_SYSCTL, 32'h1);
      `CHK({nesting_allowed, hw_stack_active}, 2'h1)
      wr(CICP_ADDR_SYSCTL, 32'h2);
      `CHK({nesting_allowed, hw_stack_active}, 2'h2)
   endtask
   task automatic t_vec();
      logic [31:0] tv[4] = '{32'h1000, 32'h1001, 32'h1003, 32'h2002};
      logic [31:0] b;
      for (int i = 0; i < 4; i++)
      begin
         b = {tv[i][31:2], 2'h0};
         wr(CICP_ADDR_TVEC, tv[i]);
         core_u.trap(1'b1, 8'h03);
         `CHK({trap_valid, trap_pc, trap_vec_absolute}, {1'b1, b + (tv[i][0] ? 32'hC : 32'h0), tv[i][0] & tv[i][1]})
         core_u.trap(1'b0, 8'h03);
         `CHK({trap_valid, trap_pc}, {1'b1, b})
      end
   endtask
   task automatic t_pmp();
      chk_mem(1'b1, 3'h4, 32'h100, 1'b1);
      wr(CICP_ADDR_PMPADDR, 32'h40);
      wr(CICP_ADDR_PMPCFG, 32'h11);
      chk_mem(1'b1, 3'h4, 32'h100, 1'b0);
      chk_mem(1'b1, 3'h2, 32'h100, 1'b1);
      chk_mem(1'b1, 3'h4, 32'h104, 1'b1);
      chk_mem(1'b0, 3'h2, 32'h100, 1'b0);
      wr(CICP_ADDR_PMPADDR + 12'h1, 32'h43);
      wr(CICP_ADDR_PMPCFG, 32'h1F91);
      chk_mem(1'b1, 3'h2, 32'h11C, 1'b0);
      chk_mem(1'b1, 3'h1, 32'h104, 1'b0);
      chk_mem(1'b1, 3'h2, 32'h100, 1'b1);
      chk_mem(1'b0, 3'h2, 32'h100, 1'b1);
      wr(CICP_ADDR_PMPADDR, 32'h50);
      rd(CICP_ADDR_PMPADDR, 32'h40);
      rd(CICP_ADDR_PMPCFG, 32'h1F91);
   endtask
   initial
   begin
      rst = 1'b1;
      priv_machine = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_priv();
      t_sysctl();
      t_vec();
      t_pmp();
      give_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
